// ### design/sjh_scan_io.sv
`timescale 1ns/1ps
`include "sjh_defs.svh"
// Summary of operation
// [RULE1] Either emergency-stop input reading open forces laser emission off at once and holds laser_source_off.
// [RULE2] The outside party keeps both emergency-stop inputs closed whenever scanning is driven from a host.
// [RULE3] The layout number is the ten select inputs read as one unsigned binary word, weights 1 to 512.
// [RULE4] Closing the confirmation strobe makes the device capture the word present on the select inputs.
// [RULE5] After taking a valid layout number the device turns its layout-confirmation output on.
// [RULE6] The carriage strobe output turns on when scanning reaches a point where the carriage may move.
// [RULE7] Scanning resumes only after the carriage controller raises its operation-complete acknowledge.
// [RULE8] A captured zero is used as layout one, so the held number always lies in 1 to 1023.
// [RULE9] Capture happens on the rising edge of the strobe, never on its level.
// [RULE10] The strobe counts only while startup-ready is on and laser-emitting is off.
// [RULE11] If no confirmation is given one second after a strobe the unregistered-layout error is raised.
// [RULE12] The carriage strobe drops once the acknowledge is seen, one handshake per move.
module sjh_scan_io #(
  parameter int unsigned UNREG_CYCLES = `SJH_UNREG_CYCLES
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic ESTOP_A_CLOSED,
  input wire logic ESTOP_B_CLOSED,
  input wire sjh_pkg::sjh_layout_t LAYOUT_SELECT_BIT,
  input wire logic CONFIRM_STROBE,
  input wire logic MOVE_DONE_ACK,
  input wire logic LAYOUT_VALID,
  output logic LAYOUT_CONFIRM,
  output logic LASER_SOURCE_OFF,
  output logic LASER_EMIT,
  output logic STARTUP_READY,
  output logic CARRIAGE_STROBE,
  output logic SCAN_HOLD,
  output logic UNREG_ERROR,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [4:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ
);
  import sjh_pkg::*;

  logic estop_open;
  logic strobe_q;
  logic strobe_rise;
  logic strobe_ok;
  logic capture;
  logic confirm_q;
  logic unreg_q;
  logic waiting_q;
  logic [`SJH_TMR_W-1:0] tmr_q;
  sjh_layout_t layout_q;
  logic ready_q;
  logic emit_req_q;
  logic move_req_q;
  logic laser_q;
  sjh_move_t mv_q;
  logic [`SJH_IRQ_W-1:0] irq_stat_q;
  logic [`SJH_IRQ_W-1:0] irq_mask_q;
  logic [`SJH_IRQ_W-1:0] irq_evt;
  logic ack_q;
  logic [31:0] dat_q;
  logic wb_req;
  logic wb_wr;
  logic ctrl_wr;
  logic clr_confirm;
  logic move_done;
  logic move_start;

  // ---------------------------------------------------------------------------
  // Emergency stop
  // ---------------------------------------------------------------------------
  // Either contact open is enough; combinational so emission drops in the same cycle
  assign estop_open = !ESTOP_A_CLOSED || !ESTOP_B_CLOSED; // RULE1 RULE2

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      laser_q <= 1'b0;
    end else begin
      laser_q <= emit_req_q && !estop_open && mv_q == SJH_MV_IDLE;
    end
  end

  assign LASER_EMIT = laser_q && !estop_open; // RULE1 RULE7
  assign LASER_SOURCE_OFF = estop_open; // RULE1
  assign STARTUP_READY = ready_q;

  // ---------------------------------------------------------------------------
  // Layout number capture
  // ---------------------------------------------------------------------------
  assign strobe_rise = CONFIRM_STROBE && !strobe_q; // RULE9
  assign strobe_ok = ready_q && !LASER_EMIT; // RULE10
  assign capture = strobe_rise && strobe_ok; // RULE4 RULE10

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= CONFIRM_STROBE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      layout_q <= `SJH_LAYOUT_ONE;
    end else if (capture) begin
      // Zero is not a layout; fold it onto the first one
      layout_q <= (LAYOUT_SELECT_BIT == `SJH_LAYOUT_ZERO) ? `SJH_LAYOUT_ONE : LAYOUT_SELECT_BIT; // RULE3 RULE8
    end
  end

  // Confirmation waits for the layout store to accept the number
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      waiting_q <= 1'b0;
      tmr_q <= '0;
      confirm_q <= 1'b0;
      unreg_q <= 1'b0;
    end else if (capture) begin
      waiting_q <= 1'b1;
      tmr_q <= '0;
      confirm_q <= 1'b0;
      unreg_q <= 1'b0;
    end else if (waiting_q && LAYOUT_VALID) begin
      waiting_q <= 1'b0;
      confirm_q <= 1'b1; // RULE5
    end else if (waiting_q) begin
      if (tmr_q == `SJH_TMR_W'(UNREG_CYCLES - 1)) begin
        waiting_q <= 1'b0;
        unreg_q <= 1'b1; // RULE11
      end else begin
        tmr_q <= tmr_q + 1'b1;
      end
    end else if (clr_confirm) begin
      confirm_q <= 1'b0;
      unreg_q <= 1'b0;
    end
  end

  assign LAYOUT_CONFIRM = confirm_q;
  assign UNREG_ERROR = unreg_q;

  // ---------------------------------------------------------------------------
  // Carriage handshake
  // ---------------------------------------------------------------------------
  assign move_start = mv_q == SJH_MV_IDLE && move_req_q;
  assign move_done = mv_q == SJH_MV_PERMIT && MOVE_DONE_ACK;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      mv_q <= SJH_MV_IDLE;
    end else begin
      case (mv_q)
        SJH_MV_IDLE: begin
          if (move_req_q) begin
            mv_q <= SJH_MV_PERMIT; // RULE6
          end
        end
        SJH_MV_PERMIT: begin
          if (MOVE_DONE_ACK) begin
            mv_q <= SJH_MV_RELEASE; // RULE7 RULE12
          end
        end
        SJH_MV_RELEASE: begin
          // A held acknowledge must not start the next move early
          if (!MOVE_DONE_ACK) begin
            mv_q <= SJH_MV_IDLE;
          end
        end
        default: begin
          mv_q <= SJH_MV_IDLE;
        end
      endcase
    end
  end

  assign CARRIAGE_STROBE = mv_q == SJH_MV_PERMIT; // RULE6 RULE12
  assign SCAN_HOLD = mv_q != SJH_MV_IDLE; // RULE7

  // ---------------------------------------------------------------------------
  // Wishbone slave, answers one cycle after the request
  // ---------------------------------------------------------------------------
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_q;
  assign wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
  assign ctrl_wr = wb_wr && WB_ADR_I == 5'(`SJH_ADR_CTRL);
  assign clr_confirm = ctrl_wr && WB_DAT_I[`SJH_CTRL_CONFIRM_CLR];

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ready_q <= 1'b0;
      emit_req_q <= 1'b0;
      move_req_q <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ready_q <= WB_DAT_I[`SJH_CTRL_READY];
        emit_req_q <= WB_DAT_I[`SJH_CTRL_EMIT_REQ];
      end
      // Move request is a self-clearing pulse
      move_req_q <= ctrl_wr && WB_DAT_I[`SJH_CTRL_MOVE_REQ];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      irq_mask_q <= '0;
    end else if (wb_wr && WB_ADR_I == 5'(`SJH_ADR_IRQ_MASK)) begin
      irq_mask_q <= WB_DAT_I[`SJH_IRQ_W-1:0];
    end
  end

  assign irq_evt[`SJH_IRQ_ESTOP] = estop_open;
  assign irq_evt[`SJH_IRQ_LAYOUT] = waiting_q && LAYOUT_VALID && !capture;
  assign irq_evt[`SJH_IRQ_UNREG] = waiting_q && !LAYOUT_VALID && !capture && tmr_q == `SJH_TMR_W'(UNREG_CYCLES - 1);
  assign irq_evt[`SJH_IRQ_MOVE_DONE] = move_done;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      irq_stat_q <= '0;
    end else if (wb_wr && WB_ADR_I == 5'(`SJH_ADR_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~WB_DAT_I[`SJH_IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= wb_req;
      dat_q <= '0;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          5'(`SJH_ADR_CTRL): dat_q <= {29'h0, 1'b0, emit_req_q, ready_q};
          5'(`SJH_ADR_STAT): dat_q <= {24'h0, move_start, SCAN_HOLD, CARRIAGE_STROBE, unreg_q,
                                      confirm_q, waiting_q, LASER_EMIT, estop_open};
          5'(`SJH_ADR_IRQ_STAT): dat_q <= {28'h0, irq_stat_q};
          5'(`SJH_ADR_IRQ_MASK): dat_q <= {28'h0, irq_mask_q};
          `SJH_ADR_LAYOUT: dat_q <= {22'h0, layout_q};
          default: dat_q <= '0;
        endcase
      end
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_estop_off;
    @(posedge MCLK) disable iff (SYS_RST) estop_open |-> !LASER_EMIT && LASER_SOURCE_OFF;
  endproperty
  a_estop_off: assert property (p_estop_off) else $error("laser on during estop"); // RULE1

  property p_layout_word;
    @(posedge MCLK) disable iff (SYS_RST)
      capture && LAYOUT_SELECT_BIT != `SJH_LAYOUT_ZERO |=> layout_q == $past(LAYOUT_SELECT_BIT);
  endproperty
  a_layout_word: assert property (p_layout_word) else $error("layout word not captured"); // RULE3 RULE4

  property p_zero_is_one;
    @(posedge MCLK) disable iff (SYS_RST) capture && LAYOUT_SELECT_BIT == `SJH_LAYOUT_ZERO |=> layout_q == `SJH_LAYOUT_ONE;
  endproperty
  a_zero_is_one: assert property (p_zero_is_one) else $error("zero layout not mapped to one"); // RULE8

  property p_confirm;
    @(posedge MCLK) disable iff (SYS_RST) waiting_q && LAYOUT_VALID && !capture |=> LAYOUT_CONFIRM;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirmation missing"); // RULE5

  property p_level_ignored;
    @(posedge MCLK) disable iff (SYS_RST) capture |-> !$past(CONFIRM_STROBE);
  endproperty
  a_level_ignored: assert property (p_level_ignored) else $error("capture on strobe level"); // RULE9

  property p_gate;
    @(posedge MCLK) disable iff (SYS_RST)
      strobe_rise && (!STARTUP_READY || LASER_EMIT) |=> $stable(layout_q) && !$rose(waiting_q);
  endproperty
  a_gate: assert property (p_gate) else $error("strobe honoured while gated"); // RULE10

  property p_unreg;
    @(posedge MCLK) disable iff (SYS_RST) irq_evt[`SJH_IRQ_UNREG] |=> UNREG_ERROR && !LAYOUT_CONFIRM;
  endproperty
  a_unreg: assert property (p_unreg) else $error("unregistered error missing"); // RULE11

  sequence s_permit;
    CARRIAGE_STROBE && !MOVE_DONE_ACK;
  endsequence
  sequence s_acked;
    CARRIAGE_STROBE && MOVE_DONE_ACK ##1 !CARRIAGE_STROBE && SCAN_HOLD;
  endsequence
  property p_handshake;
    @(posedge MCLK) disable iff (SYS_RST) s_permit ##1 MOVE_DONE_ACK |-> s_acked;
  endproperty
  a_handshake: assert property (p_handshake) else $error("carriage handshake broken"); // RULE7 RULE12

  property p_move_start;
    @(posedge MCLK) disable iff (SYS_RST) move_start |=> CARRIAGE_STROBE ##1 !LASER_EMIT;
  endproperty
  a_move_start: assert property (p_move_start) else $error("carriage strobe not raised"); // RULE6
endmodule : sjh_scan_io

// ### pkg/sjh_defs.svh
`ifndef SJH_DEFS_SVH
`define SJH_DEFS_SVH
// -----------------------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// -----------------------------------------------------------------------------
`define SJH_ADR_CTRL 4'h0
`define SJH_ADR_STAT 4'h4
`define SJH_ADR_IRQ_STAT 4'h8
`define SJH_ADR_IRQ_MASK 4'hc
`define SJH_ADR_LAYOUT 5'h10
// -----------------------------------------------------------------------------
// Control bits
// -----------------------------------------------------------------------------
`define SJH_CTRL_READY 0
`define SJH_CTRL_EMIT_REQ 1
`define SJH_CTRL_MOVE_REQ 2
`define SJH_CTRL_CONFIRM_CLR 3
// -----------------------------------------------------------------------------
// Interrupt status bits
// -----------------------------------------------------------------------------
`define SJH_IRQ_ESTOP 0
`define SJH_IRQ_LAYOUT 1
`define SJH_IRQ_UNREG 2
`define SJH_IRQ_MOVE_DONE 3
`define SJH_IRQ_W 4
// -----------------------------------------------------------------------------
// Layout number and timing
// -----------------------------------------------------------------------------
`define SJH_LAYOUT_W 10
`define SJH_LAYOUT_ZERO 10'h000
`define SJH_LAYOUT_ONE 10'h001
`define SJH_CLK_HZ 40000000
`define SJH_UNREG_TIMEOUT_MS 1000
`define SJH_UNREG_CYCLES (`SJH_CLK_HZ / 1000 * `SJH_UNREG_TIMEOUT_MS)
`define SJH_TMR_W 26
`endif

// ### pkg/sjh_pkg.sv
package sjh_pkg;
  typedef enum logic [1:0] {
    SJH_MV_IDLE,
    SJH_MV_PERMIT,
    SJH_MV_RELEASE
  } sjh_move_t;
  typedef logic [9:0] sjh_layout_t;
endpackage : sjh_pkg

// ### verif/sjh_axis_model.sv
`timescale 1ns/1ps
// ----
// Carriage controller
// ----
module sjh_axis_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic carriage_strobe,
  input wire logic [3:0] ack_dly,
  output logic move_done_ack
);
  logic [3:0] cnt_q;
  // Move takes ack_dly+1 cycles; ack is withdrawn as soon as strobe drops
  always_ff @(posedge mclk) begin
    if (sys_rst || !carriage_strobe) begin
      cnt_q <= 4'h0;
      move_done_ack <= 1'b0;
    end else if (cnt_q == ack_dly) begin
      move_done_ack <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : sjh_axis_model

// ### verif/testbench.sv
`timescale 1ns/1ps
`include "sjh_defs.svh"
module testbench;
  import sjh_pkg::*;
  localparam logic [4:0] CTRL = 5'(`SJH_ADR_CTRL);
  localparam logic [4:0] IST = 5'(`SJH_ADR_IRQ_STAT);
  localparam logic [4:0] STA = 5'(`SJH_ADR_STAT);
  localparam int UNREG_N = 20;
  localparam logic [4:0] MSK = 5'(`SJH_ADR_IRQ_MASK);
  localparam logic [4:0] LAY = `SJH_ADR_LAYOUT;
  logic mclk, sys_rst, est_a, est_b, strobe, valid, ack, cyc, stb, we, wack, irq;
  logic confirm, laser_source_off, emit, ready, car_stb, hold, unreg;
  logic [3:0] dly, wsel;
  sjh_layout_t sel_bits;
  logic [4:0] adr;
  logic [31:0] wdat, rdat, q;
  int bad_count, compares, tick, n, v, exp_q[$];
  sjh_scan_io #(.UNREG_CYCLES(UNREG_N)) dut_u (.MCLK(mclk), .SYS_RST(sys_rst),
    .ESTOP_A_CLOSED(est_a), .ESTOP_B_CLOSED(est_b), .LAYOUT_SELECT_BIT(sel_bits),
    .CONFIRM_STROBE(strobe), .MOVE_DONE_ACK(ack), .LAYOUT_VALID(valid),
    .LAYOUT_CONFIRM(confirm), .LASER_SOURCE_OFF(laser_source_off), .LASER_EMIT(emit),
    .STARTUP_READY(ready), .CARRIAGE_STROBE(car_stb), .SCAN_HOLD(hold),
    .UNREG_ERROR(unreg), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(wsel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(wack), .IRQ(irq));
  sjh_axis_model axis_u (.mclk(mclk), .sys_rst(sys_rst), .carriage_strobe(car_stb),
    .ack_dly(dly), .move_done_ack(ack));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task cy(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cy
  task wb(input logic [4:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wsel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(n == 2, "bus ack latency");
  endtask : wb
  task final_report;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  always @(posedge mclk) begin
    tick++;
    if (tick == 6000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    {cyc, stb, we, strobe, valid, sys_rst} = 6'h01;
    {est_a, est_b, dly, wsel, adr, wdat, sel_bits} = 0;
    void'($urandom(29676));
    est_a = 1'b1;
    est_b = 1'b1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    cy(1);
    chk({confirm, laser_source_off, emit, ready, car_stb, hold, unreg, irq} === 8'h00, "reset outs");
    wb(LAY, 0, 4'h0, 0);
    chk(q[9:0] === 10'h001, "reset layout");
    wb(5'h14, 0, 4'h0, 0);
    chk(q === 32'h0, "unmapped");
    wb(CTRL, 1, 4'h1, 32'h3);
    wb(CTRL, 1, 4'he, 32'h0);
    wb(CTRL, 0, 4'h0, 0);
    chk(q[1:0] === 2'h3 && emit === 1'b1 && ready === 1'b1, "ctrl sel");
    @(posedge mclk) est_a <= 1'b0;
    cy(1);
    chk(laser_source_off === 1'b1 && emit === 1'b0 && irq === 1'b0, "estop a");
    wb(MSK, 1, 4'h1, 32'h1);
    cy(1);
    chk(irq === 1'b1, "estop irq");
    @(posedge mclk);
    est_a <= 1'b1;
    est_b <= 1'b0;
    cy(1);
    chk(laser_source_off === 1'b1 && emit === 1'b0, "estop b");
    wb(STA, 0, 4'h0, 0);
    chk(q[1:0] === 2'h1, "stat estop");
    @(posedge mclk) est_b <= 1'b1;
    wb(IST, 1, 4'h1, 32'hf);
    cy(2);
    chk(irq === 1'b0 && laser_source_off === 1'b0 && emit === 1'b1, "estop clear");
    $display("test estop done");
    wb(CTRL, 1, 4'h1, 32'h9);
    wb(MSK, 1, 4'h1, 32'h2);
    @(posedge mclk) valid <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 0 : (i == 1) ? 1023 : $urandom_range(1, 1023);
      exp_q.push_back((v == 0) ? 1 : v);
      @(posedge mclk);
      sel_bits <= 10'(v);
      strobe <= 1'b1;
      cy(4);
      chk(confirm === 1'b1 && irq === 1'b1, "confirm");
      wb(LAY, 0, 4'h0, 0);
      chk(q[9:0] === 10'(exp_q.pop_front()), "layout");
      @(posedge mclk) strobe <= 1'b0;
      wb(CTRL, 1, 4'h1, 32'h9);
      wb(IST, 1, 4'h1, 32'h2);
      cy(1);
      chk(confirm === 1'b0 && irq === 1'b0, "confirm clear");
    end
    @(posedge mclk);
    sel_bits <= 10'h155;
    strobe <= 1'b1;
    cy(4);
    @(posedge mclk) sel_bits <= 10'h2aa;
    wb(CTRL, 1, 4'h1, 32'h3);
    @(posedge mclk) strobe <= 1'b0;
    cy(2);
    @(posedge mclk) strobe <= 1'b1;
    wb(LAY, 0, 4'h0, 0);
    chk(q[9:0] === 10'h155, "edge and gate");
    $display("test layout done");
    @(posedge mclk);
    strobe <= 1'b0;
    valid <= 1'b0;
    wb(CTRL, 1, 4'h1, 32'h9);
    @(posedge mclk) strobe <= 1'b1;
    cy(UNREG_N);
    chk(unreg === 1'b0, "unreg early");
    cy(1);
    chk(unreg === 1'b1 && confirm === 1'b0, "unreg");
    wb(IST, 0, 4'h0, 0);
    chk(q[2] === 1'b1, "unreg irq");
    @(posedge mclk) strobe <= 1'b0;
    wb(CTRL, 1, 4'h1, 32'h9);
    cy(1);
    chk(unreg === 1'b0, "unreg clear");
    $display("test unreg done");
    wb(CTRL, 1, 4'h1, 32'h3);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) dly <= 4'($urandom_range(1, 8));
      wb(CTRL, 1, 4'h1, 32'h7);
      for (n = 0; car_stb !== 1'b1 && n < 10; n++) cy(1);
      chk(car_stb === 1'b1, "carriage strobe");
      cy(2);
      chk(hold === 1'b1 && emit === 1'b0, "scan held");
      for (n = 0; ack !== 1'b1 && n < 20; n++) cy(1);
      cy(1);
      chk(car_stb === 1'b0 && hold === 1'b1, "strobe drop");
      for (n = 0; hold !== 1'b0 && n < 10; n++) cy(1);
      cy(3);
      chk(hold === 1'b0 && emit === 1'b1, "scan resume");
      wb(IST, 0, 4'h0, 0);
      chk(q[3] === 1'b1, "move irq");
      wb(IST, 1, 4'h1, 32'h8);
    end
    $display("test carriage done");
    @(posedge mclk) sys_rst <= 1'b1;
    cy(2);
    @(posedge mclk) sys_rst <= 1'b0;
    cy(1);
    chk({confirm, laser_source_off, emit, ready, car_stb, hold, unreg, irq} === 8'h00, "mid reset outs");
    @(posedge mclk);
    sel_bits <= 10'h0ff;
    strobe <= 1'b1;
    cy(3);
    wb(LAY, 0, 4'h0, 0);
    chk(q[9:0] === 10'h001, "ready gate");
    @(posedge mclk) strobe <= 1'b0;
    $display("test reset done");
    final_report();
  end
endmodule : testbench
